// ---- src/ddr2_pin_if.v ----
// device-side command, address, mask and termination pin logic
`timescale 1ns/1ps
`include "ddr2_pin_consts.vh"

module ddr2_pin_if (
    input wire sys_clk,
    input wire rst_n,
    input wire org_x16,
    input wire link_ck,
    input wire clock_enable,
    input wire rank_select_n,
    input wire row_strobe_n,
    input wire column_strobe_n,
    input wire write_strobe_n,
    input wire [`BANK_W-1:0] bank_select,
    input wire [`ADDR_W-1:0] address_lines,
    input wire termination_enable,
    input wire lower_byte_mask,
    input wire upper_byte_mask,
    input wire [`DQ_W-1:0] dq_in,
    output reg [`DQ_W-1:0] dq_out,
    output reg dq_oe_n,
    input wire lower_byte_strobe_in,
    input wire upper_byte_strobe_in,
    output reg lower_byte_strobe_out,
    output reg upper_byte_strobe_out,
    output reg strobe_oe_n,
    output reg read_only_strobe_out,
    output reg read_only_strobe_oe_n,
    output reg term_data_on,
    output reg term_strobe_on,
    output reg term_mask_on,
    output reg term_read_strobe_on,
    output reg cmd_valid,
    output reg [2:0] cmd_code,
    output reg [`BANK_W-1:0] cmd_bank,
    output reg [`ADDR_W-1:0] cmd_addr,
    output reg [3:0] bank_open,
    output reg [3:0] power_state,
    output reg [`ADDR_W-1:0] base_mode,
    output reg [`ADDR_W-1:0] ext_mode,
    output reg rd_beat_req,
    input wire [`DQ_W-1:0] rd_word,
    output wire wr_valid,
    input wire wr_ready,
    output wire [`DQ_W-1:0] wr_data,
    output wire [1:0] wr_byte_en,
    output reg wr_overrun
);
    localparam PW_ACTIVE = 4'b0001;
    localparam PW_PRE_PD = 4'b0010;
    localparam PW_ACT_PD = 4'b0100;
    localparam PW_SELF = 4'b1000;

    // synchronised pin levels
    wire [`SYNC_W-1:0] raw_pins;
    wire [`SYNC_W-1:0] s_pins;
    wire s_ck;
    wire s_cke;
    wire s_cs_n;
    wire [2:0] s_cmd;
    wire [`BANK_W-1:0] s_bank;
    wire [`ADDR_W-1:0] s_addr;
    wire s_odt;
    wire s_lower_byte_strobe;
    wire s_ldm;
    wire s_udm;
    wire [`DQ_W-1:0] s_dq;

    assign raw_pins = {link_ck, clock_enable, rank_select_n, row_strobe_n,
        column_strobe_n, write_strobe_n, bank_select, address_lines,
        termination_enable, lower_byte_strobe_in, upper_byte_strobe_in,
        lower_byte_mask, upper_byte_mask, dq_in, 1'b0};

    pin_sync #(
        .W(`SYNC_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(raw_pins),
        .pin_out(s_pins)
    );

    assign s_ck = s_pins[43];
    assign s_cke = s_pins[42];
    assign s_cs_n = s_pins[41];
    assign s_cmd = s_pins[40:38];
    assign s_bank = s_pins[37:36];
    assign s_addr = s_pins[35:22];
    assign s_odt = s_pins[21];
    assign s_lower_byte_strobe = s_pins[20];
    assign s_ldm = s_pins[18];
    assign s_udm = s_pins[17];
    assign s_dq = s_pins[16:1];

    // burst beats from the base register length field
    function [3:0] burst_beats;
        input [2:0] code;
        begin
            case (code)
                `BURST_CODE_8: burst_beats = `BURST_BEATS_8;
                default: burst_beats = `BURST_BEATS_4;
            endcase
        end
    endfunction

    // one-hot bank decode
    function [3:0] bank_bit;
        input [`BANK_W-1:0] b;
        begin
            bank_bit = 4'h1 << b;
        end
    endfunction

    reg ck_q;
    reg dqs_q;
    reg cke_prev_q;
    reg org_x16_q;
    reg odt_q;
    reg [3:0] rd_left_q;
    reg [3:0] wr_left_q;
    reg rd_strobe_q;

    wire ck_rise;
    wire ck_edge;
    wire dqs_edge;
    wire cmd_sel;
    wire all_idle;
    wire term_req;
    wire read_only_strobe_mode;
    wire [1:0] mask_eff;
    wire beat_push;
    wire buf_in_ready;
    wire [`DQ_W+1:0] buf_out;

    assign ck_rise = s_ck & ~ck_q;
    assign ck_edge = s_ck ^ ck_q;
    assign dqs_edge = s_lower_byte_strobe ^ dqs_q;
    // rank select high masks the command; commands are ignored outside the active power state
    assign cmd_sel = ck_rise & ~s_cs_n & s_cke & (power_state == PW_ACTIVE);
    assign all_idle = (bank_open == `BANKS_IDLE);
    // termination off when both level bits are zero or the sampled termination pin is low
    assign term_req = odt_q & (ext_mode[`EXT_TERM_LO_BIT] | ext_mode[`EXT_TERM_HI_BIT]);
    assign read_only_strobe_mode = ~org_x16_q & ext_mode[`EXT_READ_ONLY_STROBE_BIT];
    // mask per byte; narrow parts use one mask for the word, and none when the read-only strobe mode is on
    assign mask_eff = read_only_strobe_mode ? 2'h0 :
        (org_x16_q ? {s_udm, s_ldm} : {s_ldm, s_ldm});
    assign beat_push = (wr_left_q != 4'h0) & dqs_edge & (power_state == PW_ACTIVE)
        & ~(&mask_eff);

    beat_buffer #(
        .W(`DQ_W + 2)
    ) u_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(beat_push),
        .in_ready(buf_in_ready),
        .in_data({~mask_eff, s_dq}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(buf_out)
    );

    assign wr_byte_en = buf_out[`DQ_W+1:`DQ_W];
    assign wr_data = buf_out[`DQ_W-1:0];

    // edge history and organisation strap
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            ck_q <= 1'b0;
            dqs_q <= 1'b0;
            org_x16_q <= org_x16;
            odt_q <= 1'b0;
        end else begin
            ck_q <= s_ck;
            dqs_q <= s_lower_byte_strobe;
            odt_q <= ck_rise ? s_odt : odt_q;
        end
    end

    // command decode, bank state and mode registers
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            cmd_valid <= 1'b0;
            cmd_code <= `CMD_NOP;
            cmd_bank <= {`BANK_W{1'b0}};
            cmd_addr <= {`ADDR_W{1'b0}};
            bank_open <= `BANKS_IDLE;
            base_mode <= `MODE_RESET;
            ext_mode <= `MODE_RESET;
        end else begin
            cmd_valid <= 1'b0;
            if (cmd_sel) begin
                cmd_valid <= 1'b1;
                cmd_code <= s_cmd;
                cmd_bank <= s_bank;
                cmd_addr <= s_addr;
                case (s_cmd)
                    `CMD_ACTIVATE: begin
                        bank_open <= bank_open | bank_bit(s_bank);
                    end
                    `CMD_PRECHARGE: begin
                        if (s_addr[`PRECHARGE_ALL_BIT]) begin
                            bank_open <= `BANKS_IDLE;
                        end else begin
                            bank_open <= bank_open & ~bank_bit(s_bank);
                        end
                    end
                    `CMD_READ, `CMD_WRITE: begin
                        if (s_addr[`AUTO_PRECHARGE_BIT]) begin
                            bank_open <= bank_open & ~bank_bit(s_bank);
                        end
                    end
                    `CMD_MODE_LOAD: begin
                        if (s_bank == `MR_BASE) begin
                            base_mode <= s_addr;
                        end else if (s_bank == `MR_EXT) begin
                            ext_mode <= s_addr;
                        end
                    end
                    default: begin
                        bank_open <= bank_open;
                    end
                endcase
            end
        end
    end

    // power state from clock enable
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            power_state <= PW_ACTIVE;
            cke_prev_q <= 1'b1;
        end else begin
            if (ck_rise) begin
                cke_prev_q <= s_cke;
            end
            case (power_state)
                PW_ACTIVE: begin
                    if (ck_rise & cke_prev_q & ~s_cke) begin
                        if (!all_idle) begin
                            power_state <= PW_ACT_PD;
                        end else if (~s_cs_n & (s_cmd == `CMD_REFRESH)) begin
                            power_state <= PW_SELF;
                        end else begin
                            power_state <= PW_PRE_PD;
                        end
                    end
                end
                PW_PRE_PD, PW_ACT_PD: begin
                    if (ck_rise & s_cke) begin
                        power_state <= PW_ACTIVE;
                    end
                end
                PW_SELF: begin
                    // no clock edge needed to leave self-refresh
                    if (s_cke) begin
                        power_state <= PW_ACTIVE;
                        cke_prev_q <= 1'b1;
                    end
                end
                default: begin
                    power_state <= PW_ACTIVE;
                end
            endcase
        end
    end

    // termination outputs per organisation
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            term_data_on <= 1'b0;
            term_strobe_on <= 1'b0;
            term_mask_on <= 1'b0;
            term_read_strobe_on <= 1'b0;
        end else begin
            // termination input stays live in power-down, not in self-refresh
            term_data_on <= term_req & (power_state != PW_SELF);
            term_strobe_on <= term_req & (power_state != PW_SELF);
            term_mask_on <= term_req & (power_state != PW_SELF) & ~read_only_strobe_mode;
            term_read_strobe_on <= term_req & (power_state != PW_SELF) & read_only_strobe_mode;
        end
    end

    // write beat counting and overrun flag
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_left_q <= 4'h0;
            wr_overrun <= 1'b0;
        end else begin
            // relies on the controller holding clock enable through the burst
            if (cmd_sel & (s_cmd == `CMD_WRITE)) begin
                wr_left_q <= burst_beats(base_mode[`BURST_MSB:`BURST_LSB]);
            end else if ((wr_left_q != 4'h0) & dqs_edge) begin
                wr_left_q <= wr_left_q - 4'h1;
            end
            if (beat_push & ~buf_in_ready) begin
                wr_overrun <= 1'b1;
            end
        end
    end

    // read beats: device drives data and strobes
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_left_q <= 4'h0;
            rd_strobe_q <= 1'b0;
            rd_beat_req <= 1'b0;
            dq_out <= {`DQ_W{1'b0}};
            dq_oe_n <= 1'b1;
            lower_byte_strobe_out <= 1'b0;
            upper_byte_strobe_out <= 1'b0;
            strobe_oe_n <= 1'b1;
            read_only_strobe_out <= 1'b0;
            read_only_strobe_oe_n <= 1'b1;
        end else begin
            rd_beat_req <= 1'b0;
            if (cmd_sel & (s_cmd == `CMD_READ)) begin
                rd_left_q <= burst_beats(base_mode[`BURST_MSB:`BURST_LSB]);
                rd_strobe_q <= 1'b0;
            end else if ((rd_left_q != 4'h0) & ck_edge) begin
                rd_left_q <= rd_left_q - 4'h1;
                rd_strobe_q <= ~rd_strobe_q;
                rd_beat_req <= 1'b1;
                dq_out <= rd_word;
                dq_oe_n <= 1'b0;
                lower_byte_strobe_out <= ~rd_strobe_q;
                upper_byte_strobe_out <= ~rd_strobe_q & org_x16_q;
                strobe_oe_n <= 1'b0;
                read_only_strobe_out <= ~rd_strobe_q & read_only_strobe_mode;
                read_only_strobe_oe_n <= ~read_only_strobe_mode;
            end else if ((rd_left_q == 4'h0) & ck_edge) begin
                dq_oe_n <= 1'b1;
                strobe_oe_n <= 1'b1;
                read_only_strobe_oe_n <= 1'b1;
                lower_byte_strobe_out <= 1'b0;
                upper_byte_strobe_out <= 1'b0;
                read_only_strobe_out <= 1'b0;
            end
        end
    end
endmodule

// ---- inc/ddr2_pin_consts.vh ----
// constants for the dram command pin interface
`ifndef DDR2_PIN_CONSTS_VH
`define DDR2_PIN_CONSTS_VH

// pin widths
`define ADDR_W 14
`define BANK_W 2
`define DQ_W 16
`define SYNC_W 44

// command codes as {row strobe, column strobe, write strobe}, active low
`define CMD_MODE_LOAD 3'h0
`define CMD_REFRESH 3'h1
`define CMD_PRECHARGE 3'h2
`define CMD_ACTIVATE 3'h3
`define CMD_WRITE 3'h4
`define CMD_READ 3'h5
`define CMD_NOP 3'h7

// mode register selection by bank_select during a load
`define MR_BASE 2'h0
`define MR_EXT 2'h1

// address bit positions
`define PRECHARGE_ALL_BIT 10
`define AUTO_PRECHARGE_BIT 10

// base mode register burst length field and encodings
`define BURST_LSB 0
`define BURST_MSB 2
`define BURST_CODE_4 3'h2
`define BURST_CODE_8 3'h3
`define BURST_BEATS_4 4'h4
`define BURST_BEATS_8 4'h8

// extended mode register fields
`define EXT_TERM_LO_BIT 2
`define EXT_TERM_HI_BIT 6
`define EXT_READ_ONLY_STROBE_BIT 11

// reset values
`define MODE_RESET 14'h0000
`define BANKS_IDLE 4'h0

`endif

// ---- src/pin_sync.v ----
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 1
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [W-1:0] pin_in,
    output reg [W-1:0] pin_out
);
    reg [W-1:0] meta_q;

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            pin_out <= {W{1'b0}};
        end else begin
            meta_q <= pin_in;
            pin_out <= meta_q;
        end
    end
endmodule

// ---- src/beat_buffer.v ----
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module beat_buffer #(
    parameter W = 18
) (
    input wire sys_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output reg [W-1:0] out_data
);
    reg [W-1:0] tail_q;
    reg tail_valid_q;
    wire pop;
    wire push;

    assign in_ready = ~tail_valid_q;
    assign pop = out_valid & out_ready;
    assign push = in_valid & ~tail_valid_q;

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            tail_valid_q <= 1'b0;
            out_data <= {W{1'b0}};
            tail_q <= {W{1'b0}};
        end else if (pop) begin
            if (tail_valid_q) begin
                out_data <= tail_q;
                tail_valid_q <= 1'b0;
            end else begin
                out_valid <= push;
                out_data <= in_data;
            end
        end else if (push) begin
            if (!out_valid) begin
                out_data <= in_data;
                out_valid <= 1'b1;
            end else begin
                tail_q <= in_data;
                tail_valid_q <= 1'b1;
            end
        end
    end
endmodule

// ---- testbench/ddr2_pin_chk.sv ----
// concurrent checks on the dram pin block ports
`timescale 1ns/1ps
`include "ddr2_pin_consts.vh"
module ddr2_pin_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire org_x16,
    input wire wr_ready,
    input wire cmd_valid,
    input wire [2:0] cmd_code,
    input wire [3:0] bank_open,
    input wire [3:0] power_state,
    input wire [`ADDR_W-1:0] ext_mode,
    input wire term_data_on,
    input wire term_read_strobe_on,
    input wire read_only_strobe_oe_n,
    input wire wr_valid,
    input wire [`DQ_W-1:0] wr_data,
    input wire [1:0] wr_byte_en,
    input wire dq_oe_n,
    input wire strobe_oe_n,
    input wire lower_byte_strobe_out
);
    wire term_ok = ext_mode[`EXT_TERM_LO_BIT] | ext_mode[`EXT_TERM_HI_BIT];
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    a_cmd_one_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("cmd_valid longer than one cycle");
    a_cmd_when_active: assert property (cmd_valid |-> $past(power_state) == 4'h1)
        else $error("command accepted outside active state");
    a_power_onehot: assert property ($onehot(power_state))
        else $error("power state not one-hot");
    a_open_by_act: assert property (|(bank_open & ~$past(bank_open))
        |-> cmd_valid && cmd_code == `CMD_ACTIVATE)
        else $error("bank opened without activate");
    a_close_by_cmd: assert property (|(~bank_open & $past(bank_open)) |-> cmd_valid)
        else $error("bank closed without command");
    a_active_pd_open: assert property (power_state[2] |-> bank_open != 4'h0)
        else $error("active power-down with all banks idle");
    a_idle_pd_closed: assert property (power_state[1] || power_state[3]
        |-> bank_open == 4'h0)
        else $error("precharge power-down with open bank");
    a_term_ignored: assert property (!term_ok [*3] |-> !term_data_on)
        else $error("termination on while disabled");
    a_x16_no_rdstrobe: assert property (org_x16
        |-> !term_read_strobe_on && read_only_strobe_oe_n)
        else $error("read strobe active on wide part");
    a_rdstrobe_mode: assert property (!read_only_strobe_oe_n
        |-> ext_mode[`EXT_READ_ONLY_STROBE_BIT])
        else $error("read strobe driven without mode bit");
    a_wr_hold: assert property (wr_valid && !wr_ready
        |=> wr_valid && $stable(wr_data) && $stable(wr_byte_en))
        else $error("write word changed while stalled");
    a_no_empty_beat: assert property (wr_valid |-> wr_byte_en != 2'h0)
        else $error("fully masked beat delivered");
    a_strobe_with_data: assert property (strobe_oe_n == dq_oe_n)
        else $error("strobe drive differs from data drive");
    a_first_strobe_high: assert property ($fell(dq_oe_n) |-> lower_byte_strobe_out)
        else $error("read burst did not start with strobe high");
    c_write: cover property (cmd_valid && cmd_code == `CMD_WRITE);
    c_self_refresh: cover property (power_state[3]);
    c_stall: cover property (wr_valid && !wr_ready);
    c_read_strobe: cover property (!read_only_strobe_oe_n);
endmodule
bind ddr2_pin_if ddr2_pin_chk ddr2_pin_chk_i (.sys_clk, .rst_n, .org_x16, .wr_ready,
    .cmd_valid, .cmd_code, .bank_open, .power_state, .ext_mode, .term_data_on,
    .term_read_strobe_on, .read_only_strobe_oe_n, .wr_valid, .wr_data, .wr_byte_en,
    .dq_oe_n, .strobe_oe_n, .lower_byte_strobe_out);

// ---- testbench/ddr2_ctl_model.sv ----
// memory controller model driving command, clock and write pins
`timescale 1ns/1ps
`include "ddr2_pin_consts.vh"
module ddr2_ctl_model (
    input wire sys_clk,
    output reg link_ck,
    output reg clock_enable,
    output reg rank_select_n,
    output reg [2:0] cmd_pins,
    output reg [`BANK_W-1:0] bank_select,
    output reg [`ADDR_W-1:0] address_lines,
    output reg [1:0] masks,
    output reg [`DQ_W-1:0] dq_in,
    output reg dqs
);
    initial begin
        link_ck = 1'b0;
        clock_enable = 1'b1;
        rank_select_n = 1'b1;
        cmd_pins = `CMD_NOP;
        bank_select = 2'h0;
        address_lines = 14'h0000;
        masks = 2'h0;
        dq_in = 16'h0000;
        dqs = 1'b0;
    end
    // link clock only runs inside frames
    task edges(input integer n);
        integer i;
        for (i = 0; i < n; i = i + 1) begin
            #62.5 link_ck = 1'b1;
            #62.5 link_ck = 1'b0;
        end
    endtask
    task cmd(input [2:0] c, input cs_n, input [1:0] b, input [13:0] a, input en);
        begin
            @(posedge sys_clk);
            #1;
            cmd_pins = c;
            rank_select_n = cs_n;
            bank_select = b;
            address_lines = a;
            clock_enable = en;
            edges(1);
            rank_select_n = 1'b1;
            cmd_pins = `CMD_NOP;
            bank_select = ~b;
            address_lines = ~a;
        end
    endtask
    task ce(input v);
        begin
            @(posedge sys_clk);
            #1;
            clock_enable = v;
        end
    endtask
    // one word and one mask pair per strobe edge
    task wr_beats(input [15:0] d, input [7:0] m);
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                @(posedge sys_clk);
                #1;
                dq_in = d + i[15:0];
                masks = m[2*i +: 2];
                repeat (4) @(posedge sys_clk);
                #1;
                dqs = ~dqs;
                repeat (5) @(posedge sys_clk);
            end
            dq_in = ~dq_in;
        end
    endtask
endmodule

// ---- testbench/ddr2_command_pin_interface_bench.sv ----
// self-checking bench for the dram command pin block
`timescale 1ns/1ps
`include "ddr2_pin_consts.vh"
module ddr2_command_pin_interface_bench;
    reg sys_clk = 1'b0, rst_n = 1'b0, org_x16 = 1'b1;
    reg termination_enable = 1'b0, wr_ready = 1'b1;
    reg [15:0] rd_word = 16'hc000;
    wire link_ck, clock_enable, rank_select_n, dqs, dq_oe_n, cmd_valid, rd_beat_req;
    wire term_data_on, term_strobe_on, term_mask_on, term_read_strobe_on;
    wire wr_valid, wr_overrun, read_only_strobe_oe_n;
    wire [2:0] cmd_pins, cmd_code;
    wire [1:0] bank_select, masks, cmd_bank, wr_byte_en;
    wire [13:0] address_lines, cmd_addr, base_mode, ext_mode;
    wire [15:0] dq_in, dq_out, wr_data;
    wire [3:0] bank_open, power_state;
    integer fails = 0, checked = 0, n_cmd = 0, n_wr = 0, n_rd = 0, cyc = 0, n;
    reg [17:0] wq [0:15];
    reg [15:0] rq [0:15];
    ddr2_ctl_model ddr2_ctl_model_i (.sys_clk, .link_ck, .clock_enable, .rank_select_n,
        .cmd_pins, .bank_select, .address_lines, .masks, .dq_in, .dqs);
    ddr2_pin_if ddr2_pin_if_i (.sys_clk, .rst_n, .org_x16, .link_ck, .clock_enable,
        .rank_select_n, .row_strobe_n(cmd_pins[2]), .column_strobe_n(cmd_pins[1]),
        .write_strobe_n(cmd_pins[0]), .bank_select, .address_lines, .termination_enable,
        .lower_byte_mask(masks[0]), .upper_byte_mask(masks[1]), .dq_in, .dq_out, .dq_oe_n,
        .lower_byte_strobe_in(dqs), .upper_byte_strobe_in(dqs), .lower_byte_strobe_out(),
        .upper_byte_strobe_out(), .strobe_oe_n(), .read_only_strobe_out(),
        .read_only_strobe_oe_n, .term_data_on, .term_strobe_on, .term_mask_on,
        .term_read_strobe_on, .cmd_valid, .cmd_code, .cmd_bank, .cmd_addr, .bank_open,
        .power_state, .base_mode, .ext_mode, .rd_beat_req, .rd_word, .wr_valid, .wr_ready,
        .wr_data, .wr_byte_en, .wr_overrun);
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cmd_valid === 1'b1) begin
            n_cmd <= n_cmd + 1;
        end
        if (wr_valid === 1'b1 && wr_ready) begin
            wq[n_wr[3:0]] <= {wr_byte_en, wr_data};
            n_wr <= n_wr + 1;
        end
        if (rd_beat_req === 1'b1) begin
            rq[n_rd[3:0]] <= dq_out;
            n_rd <= n_rd + 1;
            rd_word <= #1 rd_word + 16'h0001;
        end
        if (cyc == 6000) begin
            fails = fails + 1;
            close_out;
        end
    end
    task chk(input [8*8-1:0] what, input [17:0] exp, input [17:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("ERROR %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    task close_out;
        begin
            $display("checked %0d fails %0d", checked, fails);
            if (fails == 0 && checked > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    task go(input [2:0] c, input cs, input [1:0] b, input [13:0] a, input ce);
        ddr2_ctl_model_i.cmd(c, cs, b, a, ce);
    endtask
    task t_mode;
        begin
            go(`CMD_MODE_LOAD, 1'b0, `MR_BASE, 14'h0002, 1'b1);
            go(`CMD_MODE_LOAD, 1'b0, `MR_EXT, 14'h0044, 1'b1);
            go(`CMD_MODE_LOAD, 1'b0, 2'h2, 14'h3fff, 1'b1);
            chk("base", 14'h0002, base_mode);
            chk("ext", 14'h0044, ext_mode);
        end
    endtask
    task t_cs;
        begin
            n = n_cmd;
            go(`CMD_ACTIVATE, 1'b1, 2'h3, 14'h0123, 1'b1);
            chk("cmds", n, n_cmd);
            chk("open", 4'h0, bank_open);
        end
    endtask
    task t_bank;
        begin
            go(`CMD_ACTIVATE, 1'b0, 2'h2, 14'h1234, 1'b1);
            chk("code", `CMD_ACTIVATE, cmd_code);
            chk("bank", 2'h2, cmd_bank);
            chk("addr", 14'h1234, cmd_addr);
            go(`CMD_ACTIVATE, 1'b0, 2'h1, 14'h0055, 1'b1);
            chk("open", 4'h6, bank_open);
            go(`CMD_PRECHARGE, 1'b0, 2'h1, 14'h0000, 1'b1);
            chk("open", 4'h4, bank_open);
            go(`CMD_PRECHARGE, 1'b0, 2'h0, 14'h0400, 1'b1);
            chk("open", 4'h0, bank_open);
        end
    endtask
    task t_term;
        begin
            @(posedge sys_clk);
            #1;
            termination_enable = 1'b1;
            ddr2_ctl_model_i.edges(2);
            chk("t_data", 1'b1, term_data_on);
            chk("t_strobe", 1'b1, term_strobe_on);
            chk("t_mask", 1'b1, term_mask_on);
            chk("t_read_only_strobe", 1'b0, term_read_strobe_on);
            go(`CMD_MODE_LOAD, 1'b0, `MR_EXT, 14'h0000, 1'b1);
            ddr2_ctl_model_i.edges(2);
            chk("t_off", 1'b0, term_data_on);
            termination_enable = 1'b0;
        end
    endtask
    task t_write;
        begin
            go(`CMD_ACTIVATE, 1'b0, 2'h0, 14'h0001, 1'b1);
            n = n_wr;
            go(`CMD_WRITE, 1'b0, 2'h0, 14'h0000, 1'b1);
            ddr2_ctl_model_i.wr_beats(16'ha000, 8'h34);
            repeat (8) @(posedge sys_clk);
            #1;
            chk("wr_n", n + 3, n_wr);
            chk("wr0", {2'h3, 16'ha000}, wq[n]);
            chk("wr1", {2'h2, 16'ha001}, wq[n + 1]);
            chk("wr2", {2'h3, 16'ha003}, wq[n + 2]);
        end
    endtask
    task t_stall;
        begin
            n = n_wr;
            wr_ready = 1'b0;
            go(`CMD_WRITE, 1'b0, 2'h0, 14'h0000, 1'b1);
            ddr2_ctl_model_i.wr_beats(16'hb000, 8'h00);
            chk("overrun", 1'b1, wr_overrun);
            chk("stall_n", n, n_wr);
            @(posedge sys_clk);
            #1;
            wr_ready = 1'b1;
            repeat (8) @(posedge sys_clk);
            #1;
            chk("drain_n", n + 2, n_wr);
            chk("drain0", {2'h3, 16'hb000}, wq[n]);
        end
    endtask
    task t_read;
        begin
            n = n_rd;
            go(`CMD_READ, 1'b0, 2'h0, 14'h0000, 1'b1);
            ddr2_ctl_model_i.edges(3);
            chk("rd_n", n + 4, n_rd);
            chk("rd0", 16'hc000, rq[n]);
            chk("rd3", 16'hc003, rq[n + 3]);
            chk("oe_n", 1'b1, dq_oe_n);
        end
    endtask
    task t_power;
        begin
            go(`CMD_NOP, 1'b1, 2'h0, 14'h0000, 1'b0);
            chk("power", 4'h4, power_state);
            go(`CMD_ACTIVATE, 1'b0, 2'h3, 14'h0002, 1'b0);
            chk("open", 4'h1, bank_open);
            go(`CMD_NOP, 1'b1, 2'h0, 14'h0000, 1'b1);
            chk("power", 4'h1, power_state);
            go(`CMD_PRECHARGE, 1'b0, 2'h0, 14'h0400, 1'b1);
            go(`CMD_NOP, 1'b1, 2'h0, 14'h0000, 1'b0);
            chk("power", 4'h2, power_state);
            go(`CMD_NOP, 1'b1, 2'h0, 14'h0000, 1'b1);
            go(`CMD_REFRESH, 1'b0, 2'h0, 14'h0000, 1'b0);
            chk("power", 4'h8, power_state);
            ddr2_ctl_model_i.ce(1'b1);
            repeat (8) @(posedge sys_clk);
            #1;
            chk("power", 4'h1, power_state);
        end
    endtask
    task t_narrow;
        begin
            @(posedge sys_clk);
            #1;
            rst_n = 1'b0;
            org_x16 = 1'b0;
            repeat (4) @(posedge sys_clk);
            #1;
            rst_n = 1'b1;
            repeat (4) @(posedge sys_clk);
            #1;
            chk("rst_ovr", 1'b0, wr_overrun);
            chk("rst_pw", 4'h1, power_state);
            go(`CMD_MODE_LOAD, 1'b0, `MR_EXT, 14'h0804, 1'b1);
            termination_enable = 1'b1;
            ddr2_ctl_model_i.edges(2);
            chk("n_read_only_strobe", 1'b1, term_read_strobe_on);
            chk("n_mask", 1'b0, term_mask_on);
            termination_enable = 1'b0;
            n = n_rd;
            go(`CMD_ACTIVATE, 1'b0, 2'h0, 14'h0000, 1'b1);
            go(`CMD_READ, 1'b0, 2'h0, 14'h0000, 1'b1);
            ddr2_ctl_model_i.edges(3);
            chk("n_rd", n + 4, n_rd);
            chk("n_rd0", 16'hc004, rq[n]);
        end
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("code", `CMD_NOP, cmd_code);
        chk("power", 4'h1, power_state);
        t_mode;
        t_cs;
        t_bank;
        t_term;
        t_write;
        t_stall;
        t_read;
        t_power;
        t_narrow;
        close_out;
    end
endmodule
